// ==== verilog/uaof_filter_top.v ====
/*
 * uncore address/opcode event filter with eight 48-bit counters.
 * assumes registers are written through plain write ports (index + strobe)
 * and that one transaction request arrives per cycle at most.
 */
`timescale 1ns/1ps
`include "uaof_consts.vh"
module uaof_filter_top (
  clk,
  rst,
  ce,
  filter_wr,
  filter_wdata,
  cfg_wr,
  cfg_idx,
  cfg_wdata,
  global_wr,
  global_wdata,
  cnt_wr,
  cnt_idx,
  cnt_wdata,
  rd_idx,
  req_valid,
  req_addr,
  req_class,
  req_opcode,
  filter_rdata,
  cfg_rdata,
  global_rdata,
  cnt_rdata,
  match_pulse
);
  input  wire                   clk;
  input  wire                   rst;
  input  wire                   ce;
  input  wire                   filter_wr;
  input  wire [63:0]            filter_wdata;
  input  wire                   cfg_wr;
  input  wire [2:0]             cfg_idx;
  input  wire [63:0]            cfg_wdata;
  input  wire                   global_wr;
  input  wire [7:0]             global_wdata;
  input  wire                   cnt_wr;
  input  wire [2:0]             cnt_idx;
  input  wire [`UAOF_CNT_W-1:0] cnt_wdata;
  input  wire [2:0]             rd_idx;
  input  wire                   req_valid;
  input  wire [39:0]            req_addr;
  input  wire [3:0]             req_class;
  input  wire [3:0]             req_opcode;
  output reg  [63:0]            filter_rdata;
  output reg  [63:0]            cfg_rdata;
  output reg  [7:0]             global_rdata;
  output reg  [`UAOF_CNT_W-1:0] cnt_rdata;
  output reg                    match_pulse;

  reg  [63:0]            filter_r;
  reg  [63:0]            cfg_r [0:`UAOF_NUM_CNT-1];
  reg  [7:0]             global_en_r;
  reg                    req_valid_r;
  reg  [39:0]            req_addr_r;
  reg  [3:0]             req_class_r;
  reg  [3:0]             req_opcode_r;
  wire                   hit;
  wire [`UAOF_CNT_W-1:0] count [0:`UAOF_NUM_CNT-1];
  wire [7:0]             sel_filter;
  wire [7:0]             enabled;
  wire [7:0]             cnt_inc;
  reg  [7:0]             cnt_load;
  reg  [63:0]            cfg_rd_mux;
  reg  [`UAOF_CNT_W-1:0] cnt_rd_mux;
  integer                i;

  // filter register
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      filter_r <= `UAOF_FILTER_RESET;
    end else if (ce && filter_wr) begin
      filter_r <= filter_wdata;
    end
  end

  // per-counter event configuration and global enable
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      for (i = 0; i < `UAOF_NUM_CNT; i = i + 1) begin
        cfg_r[i] <= `UAOF_CFG_RESET;
      end
      global_en_r <= 8'h00;
    end else if (ce) begin
      if (cfg_wr) begin
        cfg_r[cfg_idx] <= cfg_wdata;
      end
      if (global_wr) begin
        global_en_r <= global_wdata;
      end
    end
  end

  // register the request so each arriving one is evaluated exactly once
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      req_valid_r  <= 1'b0;
      req_addr_r   <= 40'h00_0000_0000;
      req_class_r  <= 4'h0;
      req_opcode_r <= 4'h0;
    end else if (ce) begin
      req_valid_r  <= req_valid;
      req_addr_r   <= req_addr;
      req_class_r  <= req_class;
      req_opcode_r <= req_opcode;
    end
  end

  uaof_match u_match (
    .filter     (filter_r),
    .req_addr   (req_addr_r),
    .req_class  (req_class_r),
    .req_opcode (req_opcode_r),
    .hit        (hit)
  );

  // per-counter qualification of the filter hit
  genvar g;
  generate
    for (g = 0; g < `UAOF_NUM_CNT; g = g + 1) begin : gen_qual
      assign sel_filter[g] = (cfg_r[g][`UAOF_EVSEL_HI:`UAOF_EVSEL_LO] ==
                              `UAOF_EVSEL_ADDR_OPCODE_MATCH);
      assign enabled[g]    = cfg_r[g][`UAOF_LOCAL_EN_BIT] & global_en_r[g];
      assign cnt_inc[g]    = req_valid_r & hit & sel_filter[g] & enabled[g];
    end
  endgenerate

  // counter load index decode; a load wins over an increment
  always @* begin
    cnt_load = 8'h00;
    if (!cnt_wr) begin
      cnt_load = 8'h00;
    end else if (cnt_idx == 3'h0) begin
      cnt_load = 8'h01;
    end else if (cnt_idx == 3'h1) begin
      cnt_load = 8'h02;
    end else if (cnt_idx == 3'h2) begin
      cnt_load = 8'h04;
    end else if (cnt_idx == 3'h3) begin
      cnt_load = 8'h08;
    end else if (cnt_idx == 3'h4) begin
      cnt_load = 8'h10;
    end else if (cnt_idx == 3'h5) begin
      cnt_load = 8'h20;
    end else if (cnt_idx == 3'h6) begin
      cnt_load = 8'h40;
    end else begin
      cnt_load = 8'h80;
    end
  end

  // eight general-purpose counters, one per event configuration
  uaof_counter u_cnt0 (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .load     (cnt_load[0]),
    .load_val (cnt_wdata),
    .inc      (cnt_inc[0]),
    .count    (count[0])
  );

  uaof_counter u_cnt1 (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .load     (cnt_load[1]),
    .load_val (cnt_wdata),
    .inc      (cnt_inc[1]),
    .count    (count[1])
  );

  uaof_counter u_cnt2 (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .load     (cnt_load[2]),
    .load_val (cnt_wdata),
    .inc      (cnt_inc[2]),
    .count    (count[2])
  );

  uaof_counter u_cnt3 (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .load     (cnt_load[3]),
    .load_val (cnt_wdata),
    .inc      (cnt_inc[3]),
    .count    (count[3])
  );

  uaof_counter u_cnt4 (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .load     (cnt_load[4]),
    .load_val (cnt_wdata),
    .inc      (cnt_inc[4]),
    .count    (count[4])
  );

  uaof_counter u_cnt5 (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .load     (cnt_load[5]),
    .load_val (cnt_wdata),
    .inc      (cnt_inc[5]),
    .count    (count[5])
  );

  uaof_counter u_cnt6 (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .load     (cnt_load[6]),
    .load_val (cnt_wdata),
    .inc      (cnt_inc[6]),
    .count    (count[6])
  );

  uaof_counter u_cnt7 (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .load     (cnt_load[7]),
    .load_val (cnt_wdata),
    .inc      (cnt_inc[7]),
    .count    (count[7])
  );

  // read index decode for config and counter read-back
  always @* begin
    if (rd_idx == 3'h0) begin
      cfg_rd_mux = cfg_r[0];
      cnt_rd_mux = count[0];
    end else if (rd_idx == 3'h1) begin
      cfg_rd_mux = cfg_r[1];
      cnt_rd_mux = count[1];
    end else if (rd_idx == 3'h2) begin
      cfg_rd_mux = cfg_r[2];
      cnt_rd_mux = count[2];
    end else if (rd_idx == 3'h3) begin
      cfg_rd_mux = cfg_r[3];
      cnt_rd_mux = count[3];
    end else if (rd_idx == 3'h4) begin
      cfg_rd_mux = cfg_r[4];
      cnt_rd_mux = count[4];
    end else if (rd_idx == 3'h5) begin
      cfg_rd_mux = cfg_r[5];
      cnt_rd_mux = count[5];
    end else if (rd_idx == 3'h6) begin
      cfg_rd_mux = cfg_r[6];
      cnt_rd_mux = count[6];
    end else begin
      cfg_rd_mux = cfg_r[7];
      cnt_rd_mux = count[7];
    end
  end

  // registered read-back
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      filter_rdata <= `UAOF_FILTER_RESET;
      cfg_rdata    <= `UAOF_CFG_RESET;
      global_rdata <= 8'h00;
      cnt_rdata    <= {`UAOF_CNT_W{1'b0}};
      match_pulse  <= 1'b0;
    end else if (ce) begin
      filter_rdata <= filter_r;
      cfg_rdata    <= cfg_rd_mux;
      global_rdata <= global_en_r;
      cnt_rdata    <= cnt_rd_mux;
      match_pulse  <= req_valid_r & hit;
    end
  end
endmodule

// ==== verilog/uaof_consts.vh ====
/*
 * constants for the uncore address/opcode event filter: register fields,
 * match criteria encodings, opcode encodings and widths.
 * assumes inclusion by bare name from the design files.
 */
`ifndef UAOF_CONSTS_VH
`define UAOF_CONSTS_VH

`define UAOF_REG_W          64
`define UAOF_CNT_W          48
`define UAOF_NUM_CNT        8
`define UAOF_ADDR_HI        39
`define UAOF_ADDR_LO        3
`define UAOF_OPC_HI         43
`define UAOF_OPC_LO         40
`define UAOF_CLS_HI         47
`define UAOF_CLS_LO         44
`define UAOF_SEL_HI         63
`define UAOF_SEL_LO         61
`define UAOF_EVSEL_HI       7
`define UAOF_EVSEL_LO       0
`define UAOF_LOCAL_EN_BIT   22
`define UAOF_FILTER_RESET   64'h0000_0000_0000_0000
`define UAOF_CFG_RESET      64'h0000_0000_0000_0000

`define UAOF_SEL_OFF        3'h0
`define UAOF_SEL_ADDR       3'h4
`define UAOF_SEL_OPC        3'h2
`define UAOF_SEL_EITHER     3'h6
`define UAOF_SEL_BOTH       3'h1

`define UAOF_CLS_HOME_REQ   4'h0
`define UAOF_CLS_SNOOP_RSP  4'h1
`define UAOF_CLS_DATA_RSP   4'hE

`define UAOF_OPC_DEMAND_INSTRUCTION_FETCH   4'h2
`define UAOF_OPC_WRITEBACK_REQUEST          4'h3
`define UAOF_OPC_PREFETCH_DATA_READ         4'h4
`define UAOF_OPC_PREFETCH_READ_FOR_OWNERSHIP 4'h5
`define UAOF_OPC_PREFETCH_INSTRUCTION_FETCH 4'h6
`define UAOF_OPC_OTHER                      4'h7
`define UAOF_OPC_NON_MEMORY_TARGET          4'hF

`define UAOF_EVSEL_ADDR_OPCODE_MATCH 8'h35

`endif

// ==== verilog/uaof_match.v ====
/*
 * combinational address and opcode comparison against the filter register.
 * assumes the request fields are valid whenever req_valid is high upstream.
 */
`timescale 1ns/1ps
`include "uaof_consts.vh"
module uaof_match (
  filter,
  req_addr,
  req_class,
  req_opcode,
  hit
);
  input  wire [63:0] filter;
  input  wire [39:0] req_addr;
  input  wire [3:0]  req_class;
  input  wire [3:0]  req_opcode;
  output reg         hit;

  wire [2:0] sel;
  wire       addr_hit;
  wire       opc_hit;

  assign sel      = filter[`UAOF_SEL_HI:`UAOF_SEL_LO];
  // bits 2:0 ignored
  assign addr_hit = (req_addr[`UAOF_ADDR_HI:`UAOF_ADDR_LO] ==
                     filter[`UAOF_ADDR_HI:`UAOF_ADDR_LO]);
  // class and opcode must both match
  assign opc_hit  = (req_class == filter[`UAOF_CLS_HI:`UAOF_CLS_LO]) &&
                    (req_opcode == filter[`UAOF_OPC_HI:`UAOF_OPC_LO]);

  always @* begin
    if (sel == `UAOF_SEL_ADDR) begin
      hit = addr_hit;
    end else if (sel == `UAOF_SEL_OPC) begin
      hit = opc_hit;
    end else if (sel == `UAOF_SEL_EITHER) begin
      hit = addr_hit | opc_hit;
    end else if (sel == `UAOF_SEL_BOTH) begin
      hit = addr_hit & opc_hit;
    end else begin
      hit = 1'b0;
    end
  end
endmodule

// ==== verilog/uaof_counter.v ====
/*
 * one 48-bit general-purpose counter with load port.
 * assumes inc is at most one per cycle.
 */
`timescale 1ns/1ps
`include "uaof_consts.vh"
module uaof_counter (
  clk,
  rst,
  ce,
  load,
  load_val,
  inc,
  count
);
  input  wire                   clk;
  input  wire                   rst;
  input  wire                   ce;
  input  wire                   load;
  input  wire [`UAOF_CNT_W-1:0] load_val;
  input  wire                   inc;
  output reg  [`UAOF_CNT_W-1:0] count;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= {`UAOF_CNT_W{1'b0}};
    end else if (ce) begin
      if (load) begin
        count <= load_val;
      end else if (inc) begin
        count <= count + {{(`UAOF_CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule

// ==== tb/uaof_props.sv ====
/* checker: match pulse timing per criteria, counter freeze.
   assumes bind to uaof_filter_top with ce held high */
`timescale 1ns/1ps
module uaof_props (
  input wire        clk,
  input wire        rst,
  input wire [63:0] filter_rdata,
  input wire        req_valid,
  input wire [39:0] req_addr,
  input wire [3:0]  req_class,
  input wire [3:0]  req_opcode,
  input wire [7:0]  global_rdata,
  input wire        cnt_wr,
  input wire [2:0]  rd_idx,
  input wire [47:0] cnt_rdata,
  input wire        match_pulse
);
  wire [2:0] sel = filter_rdata[63:61];
  wire       am  = req_addr[39:3] == filter_rdata[39:3];
  wire       om  = {req_class, req_opcode} == filter_rdata[47:40];
  wire       h   = (sel == 3'h4) ? am : (sel == 3'h2) ? om :
                   (sel == 3'h6) ? (am | om) : ((sel == 3'h1) & am & om);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_hit;
    ##2 match_pulse;
  endsequence
  sequence s_miss;
    ##2 !match_pulse;
  endsequence
  AST_HIT: assert property (req_valid |-> ##2 (match_pulse == $past(h, 2)))
    else $error("match pulse differs from filter result");
  AST_ADDR: assert property ((req_valid && sel == 3'h4 && am) |-> s_hit)
    else $error("address match not counted");
  AST_OPC: assert property ((req_valid && sel == 3'h2 && om) |-> s_hit)
    else $error("opcode match not counted");
  AST_EITHER: assert property ((req_valid && sel == 3'h6 && (am || om)) |-> s_hit)
    else $error("either match not counted");
  AST_BOTH: assert property ((req_valid && sel == 3'h1 && !(am && om)) |-> s_miss)
    else $error("partial match counted");
  AST_OFF: assert property ((req_valid && sel == 3'h0) |-> s_miss)
    else $error("disabled filter hit");
  AST_IDLE: assert property (!req_valid |-> s_miss)
    else $error("hit without request");
  AST_FROZEN: assert property ((global_rdata == 8'h00 && !$past(cnt_wr) && $stable(rd_idx))
    |=> $stable(cnt_rdata)) else $error("counter moved while disabled");
endmodule
bind uaof_filter_top uaof_props props_u (.clk, .rst, .filter_rdata, .req_valid, .req_addr,
  .req_class, .req_opcode, .global_rdata, .cnt_wr, .rd_idx, .cnt_rdata, .match_pulse);

// ==== tb/uaof_req_src.sv ====
/* request source of the home logic.
   assumes tasks are called from the bench after a clock edge */
`timescale 1ns/1ps
module uaof_req_src (
  input  wire        clk,
  output reg         req_valid = 1'b0,
  output reg  [39:0] req_addr = 40'h0,
  output reg  [3:0]  req_class = 4'h0,
  output reg  [3:0]  req_opcode = 4'h0
);
  // released fields show the inverse of the last value
  task idle;
    @(posedge clk);
    req_valid <= 1'b0;
    req_addr <= ~req_addr;
    req_class <= ~req_class;
    req_opcode <= ~req_opcode;
  endtask
  task send(input [39:0] a, input [3:0] c, input [3:0] o, input g);
    if (g) idle;
    @(posedge clk);
    req_valid <= 1'b1;
    req_addr <= a;
    req_class <= c;
    req_opcode <= o;
  endtask
endmodule

// ==== tb/test_uncore_addr_opcode_event_filter.sv ====
/* bench: drives writes and requests, models hits and counters.
   assumes uaof_filter_top and uaof_req_src */
`timescale 1ns/1ps
`include "uaof_consts.vh"
`define CHK(a, x, s) begin n_compared++; if ((a) !== (x)) begin num_errors++; $display("FAIL %0t %s", $time, s); end end
module test_uncore_addr_opcode_event_filter;
  reg        clk = 1'b0, rst = 1'b1, ce = 1'b1, filter_wr = 1'b0, cfg_wr = 1'b0;
  reg        global_wr = 1'b0, cnt_wr = 1'b0;
  reg [63:0] filter_wdata = 64'h0, cfg_wdata = 64'h0, flt, r, cf [0:7];
  reg [7:0]  global_wdata = 8'h0, en, ox;
  reg [2:0]  cfg_idx = 3'h0, cnt_idx = 3'h0, rd_idx = 3'h0, sel, pv = 3'h0;
  reg [47:0] cnt_wdata = 48'h0, cm [0:7];
  reg [39:0] ax;
  reg        x;
  bit        hq [$];
  integer    num_errors = 0, n_compared = 0, cyc = 0, i, j, k, m;
  wire       req_valid, match_pulse;
  wire [39:0] req_addr;
  wire [3:0] req_class, req_opcode;
  wire [63:0] filter_rdata, cfg_rdata;
  wire [7:0] global_rdata;
  wire [47:0] cnt_rdata;
  uaof_filter_top dut_u (.clk, .rst, .ce, .filter_wr, .filter_wdata, .cfg_wr, .cfg_idx,
    .cfg_wdata, .global_wr, .global_wdata, .cnt_wr, .cnt_idx, .cnt_wdata, .rd_idx, .req_valid,
    .req_addr, .req_class, .req_opcode, .filter_rdata, .cfg_rdata, .global_rdata, .cnt_rdata,
    .match_pulse);
  uaof_req_src src_u (.clk, .req_valid, .req_addr, .req_class, .req_opcode);
  always #25 clk = ~clk;
  function bit hitm(input [39:0] a, input [3:0] c, input [3:0] o);
    bit am, om;
    am = a[39:3] == flt[39:3];
    om = {c, o} == flt[47:40];
    case (flt[63:61])
      3'h4: hitm = am;
      3'h2: hitm = om;
      3'h6: hitm = am | om;
      3'h1: hitm = am & om;
      default: hitm = 1'b0;
    endcase
  endfunction
  task wreg(input [1:0] t, input [2:0] ix, input [63:0] d);
    @(posedge clk);
    filter_wr <= t == 2'h0;
    cfg_wr <= t == 2'h1;
    global_wr <= t == 2'h2;
    cnt_wr <= t == 2'h3;
    {filter_wdata, cfg_wdata, cfg_idx, cnt_idx} <= {d, d, ix, ix};
    {global_wdata, cnt_wdata} <= {d[7:0], d[47:0]};
    @(posedge clk);
    {filter_wr, cfg_wr, global_wr, cnt_wr} <= 4'h0;
  endtask
  task req(input [39:0] a, input [3:0] c, input [3:0] o, input g);
    hq.push_back(hitm(a, c, o));
    src_u.send(a, c, o, g);
  endtask
  task rdall;
    for (i = 0; i < 8; i++) begin
      @(posedge clk);
      rd_idx <= i[2:0];
      repeat (2) @(posedge clk);
      #1;
      `CHK(cnt_rdata, cm[i], "count")
      `CHK(cfg_rdata, cf[i], "config")
    end
    `CHK(filter_rdata, flt, "filter")
    `CHK(global_rdata, 8'hDF, "global")
  endtask
  task end_sim;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    pv <= {pv[1:0], req_valid};
    if (pv[1]) begin
      x = hq.pop_front();
      `CHK(match_pulse, x, "match")
      for (j = 0; j < 8; j++) if (x && en[j]) cm[j] = cm[j] + 48'h1;
    end
    if (cyc == 2000) begin
      num_errors++;
      end_sim;
    end
  end
  initial begin
    void'($urandom(32'hBE34D225));
    repeat (2) @(posedge clk);
    `CHK(filter_rdata, 64'h0, "reset")
    rst <= 1'b0;
    for (i = 0; i < 8; i++) begin
      cf[i] = {41'h0, i != 6, 14'h0, (i == 7) ? 8'h34 : `UAOF_EVSEL_ADDR_OPCODE_MATCH};
      en[i] = (i < 6) && (i != 5);
      cm[i] = 48'h0;
      wreg(2'h1, i[2:0], cf[i]);
    end
    wreg(2'h2, 3'h0, 64'hDF);
    cm[0] = 48'hFFFF_FFFF_FFFF;
    wreg(2'h3, 3'h0, {16'h0, cm[0]});
    for (m = 0; m < 8; m++) begin
      sel = 3'(24'h8B1116 >> (21 - 3 * m));
      r = {$urandom, $urandom};
      flt = {sel, 13'h0, (m % 3 == 2) ? 4'hE : 4'(m % 3), (m % 7 == 6) ? 4'hF : 4'(m % 7 + 2),
        r[36:0], 3'h0};
      wreg(2'h0, 3'h0, flt);
      for (k = 0; k < 5; k++) begin
        r = {$urandom, $urandom};
        ax = (k == 2) ? 40'h8 : (k == 3) ? 40'h80_0000_0000 : {37'h0, r[2:0]};
        ox = (k == 1) ? 8'h10 : (k == 3) ? 8'h08 : (k == 4) ? 8'h01 : 8'h00;
        req(flt[39:0] ^ ax, flt[47:44] ^ ox[7:4], flt[43:40] ^ ox[3:0], r[40]);
      end
      src_u.idle;
      repeat (4) @(posedge clk);
      rdall;
      $display("mode %0d done", sel);
    end
    end_sim;
  end
endmodule
